/* common/ctw_pkg.sv */
package ctw_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [15:0] CTW_IDX_CTRL  = 16'h0008;
  localparam logic [15:0] CTW_IDX_COUNT = 16'h0009;
  localparam logic [15:0] CTW_IDX_SVC   = 16'h1ff0;
  localparam logic [31:0] CTW_ADDR_CTRL  = {14'h0000, CTW_IDX_CTRL, 2'b00};
  localparam logic [31:0] CTW_ADDR_COUNT = {14'h0000, CTW_IDX_COUNT, 2'b00};
  localparam logic [31:0] CTW_ADDR_SVC   = {14'h0000, CTW_IDX_SVC, 2'b00};

  // Control/status field positions
  localparam int CTW_BIT_OVF_FLAG   = 7;
  localparam int CTW_BIT_TICK_FLAG  = 6;
  localparam int CTW_BIT_OVF_EN     = 5;
  localparam int CTW_BIT_TICK_EN    = 4;
  localparam int CTW_BIT_OVF_CLR    = 3;
  localparam int CTW_BIT_TICK_CLR   = 2;
  localparam int CTW_BIT_RATE_HI    = 1;
  localparam int CTW_BIT_RATE_LO    = 0;
  localparam int CTW_BIT_SVC        = 0;

  // Values after reset
  localparam logic [1:0] CTW_RATE_RESET  = 2'h3;
  localparam logic [7:0] CTW_COUNT_RESET = 8'h00;

  // Chain geometry: prescaler stages, counter stages, chain stages
  localparam int CTW_PRESCALE_BITS = 2;
  localparam int CTW_COUNT_BITS    = 8;
  localparam int CTW_CHAIN_STAGES  = 15;
  localparam int CTW_TAP_FIRST     = 13;
  localparam int CTW_TOTAL_BITS    = CTW_PRESCALE_BITS + CTW_CHAIN_STAGES;

  // Stabilization delay after leaving stop, in bus cycles
  localparam logic [11:0] CTW_STAB_CYCLES = 12'h0fe0;
  localparam logic [2:0]  CTW_WDOG_LAST   = 3'h7;

  // Register select codes
  localparam logic [1:0] CTW_SEL_NONE  = 2'h0;
  localparam logic [1:0] CTW_SEL_CTRL  = 2'h1;
  localparam logic [1:0] CTW_SEL_COUNT = 2'h2;
  localparam logic [1:0] CTW_SEL_SVC   = 2'h3;

  typedef enum logic [2:0] {
    CTW_ST_RUN  = 3'b001,
    CTW_ST_STOP = 3'b010,
    CTW_ST_STAB = 3'b100
  } ctw_state_t;

  // Captured address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [1:0] sel;
  } ctw_aphase_t;

endpackage : ctw_pkg

/* logic/ctw_chain.sv */
`timescale 1ns/1ps

// Prescaler plus divider chain with overflow and tap rise pulses
module ctw_chain
  import ctw_pkg::*;
#(
  parameter int TOTAL_BITS = CTW_TOTAL_BITS
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       clear,
  input  wire logic [1:0] rate_sel,
  output logic      [7:0] count,
  output logic            ovf_pulse,
  output logic            tick_pulse
);

  logic [TOTAL_BITS-1:0] chain_q;
  logic [3:0]            tap_rise;
  logic                  ovf_pulse_q;
  logic                  tick_pulse_q;

  // True when the next increment sets bit idx
  function automatic logic rises(input logic [TOTAL_BITS-1:0] c, input int idx);
    logic [TOTAL_BITS-1:0] mask;
    mask = (TOTAL_BITS'(1) << (idx + 1)) - TOTAL_BITS'(1);
    return (c & mask) == (mask >> 1);
  endfunction : rises

  // Free-running chain, cleared by reset or clear request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chain_q <= '0;
    end else if (clear) begin
      chain_q <= '0;
    end else begin
      chain_q <= chain_q + TOTAL_BITS'(1);
    end
  end

  // One rise detector per selectable tap
  for (genvar g = 0; g < 4; g++) begin : g_tap
    assign tap_rise[g] = !clear && rises(chain_q, CTW_TAP_FIRST + g);
  end

  // Pulses land in the cycle the counter wraps or the tap goes high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_pulse_q  <= 1'b0;
      tick_pulse_q <= 1'b0;
    end else begin
      ovf_pulse_q  <= !clear && (chain_q[CTW_PRESCALE_BITS+CTW_COUNT_BITS-1:0] == '1);
      tick_pulse_q <= tap_rise[rate_sel];
    end
  end

  assign count      = chain_q[CTW_PRESCALE_BITS +: CTW_COUNT_BITS];
  assign ovf_pulse  = ovf_pulse_q;
  assign tick_pulse = tick_pulse_q;

endmodule : ctw_chain

/* logic/ctw_timer.sv */
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps

// Overview of operation
// - Fifteen-stage chain, first eight form counter
// - Counter advances every fourth bus clock
// - External reset clears chain, restarts from zero
// - Tick taps chain at 2^14, three more stages
// - Watchdog divides selected tick by eight
// - Watchdog expiry raises internal reset
// - Writing zero to service bit clears watchdog
// - Watchdog presence is build option or option bit
// - Overflow flag sets when counter wraps to zero
// - Tick flag sets when selected tap rises
// - Overflow request needs enable, flag, mask clear
// - Tick request needs enable, flag, mask clear
// - Writing one to overflow clear drops flag
// - Writing one to tick clear drops flag
// - Rate codes pick 2^14..2^17, reset slowest
// - Rate select also sets watchdog timeout
// - Counter register read-only, live, reset cleared
// - Chain runs in wait; enabled requests wake
// - Stop clears chain, holds it clear through delay
module ctw_timer
  import ctw_pkg::*;
#(
  parameter bit WDOG_PRESENT      = 1'b1,
  parameter bit WDOG_PROGRAMMABLE = 1'b0
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        cpu_irq_mask,
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  input  wire logic        wdog_option_en,
  output logic             irq_overflow,
  output logic             irq_tick,
  output logic             wake_req,
  output logic             wdog_reset
);

  ctw_aphase_t aphase_q;
  ctw_aphase_t aphase_d;
  ctw_state_t  state_q;
  ctw_state_t  state_d;

  logic [31:0] hrdata_q;
  logic        hreadyout_q;
  logic        hresp_q;

  logic        ovf_flag_q;
  logic        tick_flag_q;
  logic        ovf_en_q;
  logic        tick_en_q;
  logic [1:0]  rate_q;

  logic [2:0]  wdog_cnt_q;
  logic        wdog_reset_q;
  logic [11:0] stab_cnt_q;

  logic        irq_overflow_q;
  logic        irq_tick_q;
  logic        wake_req_q;

  logic        chain_clear;
  logic [7:0]  count;
  logic        ovf_pulse;
  logic        tick_pulse;
  logic        ctrl_wr;
  logic        svc_wr;
  logic        ovf_clr;
  logic        tick_clr;
  logic        wdog_active;
  logic [7:0]  ctrl_rd;

  // Map a byte address onto a register select code
  function automatic logic [1:0] decode(input logic [31:0] addr);
    logic [1:0] sel;
    sel = CTW_SEL_NONE;
    if (addr == CTW_ADDR_CTRL) begin
      sel = CTW_SEL_CTRL;
    end else if (addr == CTW_ADDR_COUNT) begin
      sel = CTW_SEL_COUNT;
    end else if (addr == CTW_ADDR_SVC) begin
      sel = CTW_SEL_SVC;
    end
    return sel;
  endfunction : decode

  // Data-phase write strobe for one register select
  function automatic logic wr_hit(input ctw_aphase_t ap, input logic [1:0] sel);
    return ap.valid && ap.write && (ap.sel == sel);
  endfunction : wr_hit

  // Service write with the service bit low clears the watchdog
  function automatic logic svc_zero(input logic wr, input logic [31:0] data);
    return wr && !data[CTW_BIT_SVC];
  endfunction : svc_zero

  // Divider chain

  // Prescaler, counter and tick taps live in one chain
  ctw_chain #(
    .TOTAL_BITS (CTW_TOTAL_BITS)
  ) i_ctw_chain (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .clear      (chain_clear),
    .rate_sel   (rate_q),
    .count      (count),
    .ovf_pulse  (ovf_pulse),
    .tick_pulse (tick_pulse)
  );

  // Stop mode sequencing

  // Next state of the stop sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      CTW_ST_RUN: begin
        if (stop_mode) begin
          state_d = CTW_ST_STOP;
        end
      end
      CTW_ST_STOP: begin
        if (!stop_mode) begin
          state_d = CTW_ST_STAB;
        end
      end
      CTW_ST_STAB: begin
        if (stab_cnt_q == CTW_STAB_CYCLES - 12'h001) begin
          state_d = CTW_ST_RUN;
        end
      end
      default: begin
        state_d = CTW_ST_RUN;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= CTW_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Stabilization delay counter, runs only while leaving stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stab_cnt_q <= 12'h000;
    end else if (state_q == CTW_ST_STAB) begin
      stab_cnt_q <= stab_cnt_q + 12'h001;
    end else begin
      stab_cnt_q <= 12'h000;
    end
  end

  // Chain held clear in stop and through the delay; wait does not halt it
  assign chain_clear = (state_q != CTW_ST_RUN) || (state_d != CTW_ST_RUN);

  // AHB-Lite slave

  // Address phase capture
  always_comb begin
    aphase_d       = '0;
    aphase_d.valid = hsel && htrans[1] && hready;
    aphase_d.write = hwrite;
    aphase_d.sel   = decode(haddr);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aphase_q <= '0;
    end else if (hready) begin
      aphase_q <= aphase_d;
    end
  end

  // Write strobes in the data phase
  assign ctrl_wr  = wr_hit(aphase_q, CTW_SEL_CTRL);
  assign svc_wr   = wr_hit(aphase_q, CTW_SEL_SVC);
  assign ovf_clr  = ctrl_wr && hwdata[CTW_BIT_OVF_CLR];
  assign tick_clr = ctrl_wr && hwdata[CTW_BIT_TICK_CLR];

  // Clear-request bits always read as zero
  assign ctrl_rd = {ovf_flag_q, tick_flag_q, ovf_en_q, tick_en_q,
                    1'b0, 1'b0, rate_q};

  // Read data sampled at the address phase edge, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (aphase_d.valid && !hwrite) begin
      case (aphase_d.sel)
        CTW_SEL_CTRL:  hrdata_q <= {24'h00_0000, ctrl_rd};
        CTW_SEL_COUNT: hrdata_q <= {24'h00_0000, count};
        default:       hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Always ready, no wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
    end else begin
      hreadyout_q <= 1'b1;
    end
  end

  // Always OKAY, no register refuses an access
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_q <= 1'b0;
    end else begin
      hresp_q <= 1'b0;
    end
  end

  // Control and flags

  // Software-written enables and rate select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_en_q  <= 1'b0;
      tick_en_q <= 1'b0;
      rate_q    <= CTW_RATE_RESET;
    end else if (ctrl_wr) begin
      ovf_en_q  <= hwdata[CTW_BIT_OVF_EN];
      tick_en_q <= hwdata[CTW_BIT_TICK_EN];
      rate_q    <= {hwdata[CTW_BIT_RATE_HI], hwdata[CTW_BIT_RATE_LO]};
    end
  end

  // Overflow flag, a wrap in the clearing cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_flag_q <= 1'b0;
    end else if (ovf_pulse) begin
      ovf_flag_q <= 1'b1;
    end else if (ovf_clr) begin
      ovf_flag_q <= 1'b0;
    end
  end

  // Tick flag, a tick in the clearing cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_flag_q <= 1'b0;
    end else if (tick_pulse) begin
      tick_flag_q <= 1'b1;
    end else if (tick_clr) begin
      tick_flag_q <= 1'b0;
    end
  end

  // Overflow request gated by enable and processor mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_overflow_q <= 1'b0;
    end else begin
      irq_overflow_q <= ovf_en_q && ovf_flag_q && !cpu_irq_mask;
    end
  end

  // Tick request gated by enable and processor mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_tick_q <= 1'b0;
    end else begin
      irq_tick_q <= tick_en_q && tick_flag_q && !cpu_irq_mask;
    end
  end

  // Wake from wait on any enabled pending timer event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_req_q <= 1'b0;
    end else begin
      wake_req_q <= wait_mode && ((ovf_en_q && ovf_flag_q) ||
                                  (tick_en_q && tick_flag_q));
    end
  end

  // Watchdog

  // Fixed at build time, or gated by an option bit when programmable
  assign wdog_active = WDOG_PRESENT && (!WDOG_PROGRAMMABLE || wdog_option_en);

  // Divide-by-eight on ticks; cleared by a zero service write, in stop and delay, or when inactive
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdog_cnt_q <= 3'h0;
    end else if (!wdog_active || chain_clear) begin
      wdog_cnt_q <= 3'h0;
    end else if (svc_zero(svc_wr, hwdata)) begin
      wdog_cnt_q <= 3'h0;
    end else if (tick_pulse) begin
      wdog_cnt_q <= wdog_cnt_q + 3'h1;
    end
  end

  // One-cycle internal reset on the eighth tick after service
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdog_reset_q <= 1'b0;
    end else begin
      wdog_reset_q <= wdog_active && !chain_clear && tick_pulse &&
                      (wdog_cnt_q == CTW_WDOG_LAST) &&
                      !svc_zero(svc_wr, hwdata);
    end
  end

  // Outputs

  assign hrdata       = hrdata_q;
  assign hreadyout    = hreadyout_q;
  assign hresp        = hresp_q;
  assign irq_overflow = irq_overflow_q;
  assign irq_tick     = irq_tick_q;
  assign wake_req     = wake_req_q;
  assign wdog_reset   = wdog_reset_q;

endmodule : ctw_timer

/* testbench/ctw_timer_assertions.sv */
`timescale 1ns/1ps

module ctw_timer_assertions
  import ctw_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        cpu_irq_mask,
  input wire logic        wait_mode,
  input wire logic        irq_overflow,
  input wire logic        irq_tick,
  input wire logic        wake_req,
  input wire logic        wdog_reset
);
  logic svc_q;

  // Service address phase taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      svc_q <= 1'b0;
    end else begin
      svc_q <= hsel && htrans[1] && hready && hwrite && (haddr == CTW_ADDR_SVC);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_bus_okay_ready: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_rdata_upper_zero: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  a_rdata_hold: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without read");
  a_ovf_irq_mask: assert property (cpu_irq_mask |=> !irq_overflow)
    else $error("overflow request while masked");
  a_tick_irq_mask: assert property (cpu_irq_mask |=> !irq_tick)
    else $error("tick request while masked");
  a_wake_needs_wait: assert property (!wait_mode |=> !wake_req)
    else $error("wake request outside wait");
  a_wdog_one_pulse: assert property (wdog_reset |=> !wdog_reset)
    else $error("watchdog reset longer than one cycle");
  a_wdog_serviced: assert property (svc_q && !hwdata[0] |-> ##2 !wdog_reset [*8])
    else $error("watchdog fired right after service");
endmodule : ctw_timer_assertions

bind ctw_timer ctw_timer_assertions i_ctw_timer_assertions (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .cpu_irq_mask(cpu_irq_mask),
  .wait_mode(wait_mode), .irq_overflow(irq_overflow), .irq_tick(irq_tick),
  .wake_req(wake_req), .wdog_reset(wdog_reset)
);

/* testbench/test_ctw_timer.sv */
`timescale 1ns/1ps

module test_ctw_timer
  import ctw_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, cpu_irq_mask, wait_mode, stop_mode;
  logic        hreadyout, hresp, irq_overflow, irq_tick, wake_req, wdog_reset;
  logic [31:0] haddr, hwdata, hrdata, rd, c0;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          err_total, samples_checked, cyc;
  int          wdog_hits = 0;

  ctw_timer i_ctw_timer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cpu_irq_mask(cpu_irq_mask), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .wdog_option_en(1'b0), .irq_overflow(irq_overflow), .irq_tick(irq_tick),
    .wake_req(wake_req), .wdog_reset(wdog_reset)
  );

  // Clock and cycle count since reset release
  initial hclk = 1'b0;
  always #20 hclk = ~hclk;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cyc <= 0;
    else cyc <= cyc + 1;
  end

  // Watchdog reset pulses seen over the run
  always @(posedge hclk) begin
    if (wdog_reset === 1'b1) wdog_hits <= wdog_hits + 1;
  end

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // One single transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
  endtask : do_reset

  task automatic wait_to(input int n);
    while (cyc < n) @(posedge hclk);
  endtask : wait_to

  task automatic wait_mod(input int m);
    do @(posedge hclk); while (cyc % 1024 != m);
  endtask : wait_mod

  initial begin
    #3_600_000;
    err_total++;
    wrap_up();
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'h2; hwdata = '0; cpu_irq_mask = 1'b0; wait_mode = 1'b0; stop_mode = 1'b0;
    err_total = 0;
    samples_checked = 0;
    do_reset();
    // Count read first, before four chain steps have passed
    bus(1'b0, CTW_ADDR_COUNT, '0);
    check(rd, 32'h0000_0000);
    bus(1'b0, CTW_ADDR_CTRL, '0);
    check(rd, 32'h0000_0003);
    bus(1'b0, 32'h0000_0100, '0);
    check(rd, 32'h0000_0000);
    // Counter advances once per four bus cycles
    bus(1'b0, CTW_ADDR_COUNT, '0);
    c0 = rd;
    repeat (61) @(posedge hclk);
    bus(1'b0, CTW_ADDR_COUNT, '0);
    check(rd - c0, 32'h0000_0010);
    // Each rate code: no tick just before its first tap rise, tick just after
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, CTW_ADDR_SVC, 32'h0000_0000);
      bus(1'b1, CTW_ADDR_CTRL, 32'h0000_0014 | 32'(r));
      bus(1'b1, CTW_ADDR_SVC, 32'h0000_0001);
      wait_to((1 << (13 + r)) - 64);
      bus(1'b0, CTW_ADDR_CTRL, '0);
      check(rd & 32'h0000_007f, 32'h0000_0010 | 32'(r));
      wait_to((1 << (13 + r)) + 64);
      bus(1'b0, CTW_ADDR_CTRL, '0);
      check(rd & 32'h0000_007f, 32'h0000_0050 | 32'(r));
      check({31'b0, irq_tick}, 32'h0000_0001);
    end
    // Overflow flag, clear, request, mask and wake
    wait_mod(100);
    bus(1'b1, CTW_ADDR_CTRL, 32'h0000_002f);
    bus(1'b0, CTW_ADDR_CTRL, '0);
    check(rd, 32'h0000_0023);
    check({31'b0, irq_overflow}, 32'h0000_0000);
    wait_mod(10);
    bus(1'b0, CTW_ADDR_CTRL, '0);
    check(rd, 32'h0000_00a3);
    check({31'b0, irq_overflow}, 32'h0000_0001);
    bus(1'b1, CTW_ADDR_CTRL, 32'h0000_0023);
    bus(1'b0, CTW_ADDR_CTRL, '0);
    check(rd, 32'h0000_00a3);
    cpu_irq_mask <= 1'b1;
    wait_mode <= 1'b1;
    repeat (3) @(posedge hclk);
    check({31'b0, irq_overflow}, 32'h0000_0000);
    check({31'b0, wake_req}, 32'h0000_0001);
    cpu_irq_mask <= 1'b0;
    wait_mode <= 1'b0;
    // Stop holds chain cleared through the stabilization delay
    stop_mode <= 1'b1;
    repeat (10) @(posedge hclk);
    stop_mode <= 1'b0;
    repeat (3900) @(posedge hclk);
    bus(1'b0, CTW_ADDR_COUNT, '0);
    check(rd, 32'h0000_0000);
    repeat (400) @(posedge hclk);
    bus(1'b0, CTW_ADDR_COUNT, '0);
    check({31'b0, rd != 32'h0000_0000}, 32'h0000_0001);
    // Reset in mid-run
    @(posedge hclk);
    do_reset();
    bus(1'b0, CTW_ADDR_COUNT, '0);
    check(rd, 32'h0000_0000);
    bus(1'b0, CTW_ADDR_CTRL, '0);
    check(rd, 32'h0000_0003);
    check(32'(wdog_hits), 32'h0000_0000);
    wrap_up();
  end
endmodule : test_ctw_timer
